// ---- hw/half_bridge_consts.vh ----
// constants for the half-bridge control and diagnosis block
`ifndef HALF_BRIDGE_CONSTS_VH
`define HALF_BRIDGE_CONSTS_VH
`define CLK_MHZ 50
`define OC_FILTER_NS 1000
`define OC_FILTER_MIN_NS 500
`define OC_FILTER_MAX_NS 2000
`define DIAG_ACT_CYCLES 5000
`define DIAG_FILT_CYCLES 3000
`define ADDR_CFG 4'h0
`define ADDR_ENABLE 4'h1
`define ADDR_CONTROL 4'h2
`define ADDR_OFFDIAG 4'h3
`define ADDR_PROTECT 4'h4
`define ADDR_ACT_TIME 4'h5
`define ADDR_FILT_TIME 4'h6
`define CFG_MODE_LSB 0
`define CFG_FREE_LSB 4
`define CFG_PAIR1_BIT 8
`define CFG_PAIR2_BIT 9
`define CTL_DIRECT_SEL_LSB 4
`define PROT_OT1_BIT 4
`define PROT_OT2_BIT 5
`define CODE_NONE 2'h0
`define CODE_OL_HS 2'h1
`define CODE_OL_LS 2'h2
`define CODE_SHORT 2'h3
`define CFG_RESET 32'h00000000
`endif

// ---- hw/off_state_channel.v ----
// per-channel off-state detection timing: activation timer then disturbance filter
`include "half_bridge_consts.vh"
module off_state_channel #(
  parameter CW = 24
) (
  input wire clk,
  input wire srst,
  input wire clkEn,
  input wire switchesOff,
  input wire [CW-1:0] actCycles,
  input wire [CW-1:0] filtCycles,
  input wire [1:0] rawCode,
  output reg codeValid,
  output reg [1:0] filtCode
);
  reg [CW-1:0] actCnt_q;
  reg [CW-1:0] filtCnt_q;
  reg [1:0] lastCode_q;

  always @(posedge clk) begin
    if (srst) begin
      actCnt_q <= {CW{1'b0}};
      filtCnt_q <= {CW{1'b0}};
      lastCode_q <= `CODE_NONE;
      codeValid <= 1'b0;
      filtCode <= `CODE_NONE;
    end else if (clkEn) begin
      if (!switchesOff) begin
        // any switch back on restarts both timers
        actCnt_q <= {CW{1'b0}};
        filtCnt_q <= {CW{1'b0}};
        codeValid <= 1'b0;
      end else if (actCnt_q < actCycles) begin
        actCnt_q <= actCnt_q + {{(CW-1){1'b0}}, 1'b1};
      end else begin
        lastCode_q <= rawCode;
        // a changed comparator result restarts the filter
        if (rawCode != lastCode_q) begin
          filtCnt_q <= {CW{1'b0}};
        end else if (filtCnt_q < filtCycles) begin
          filtCnt_q <= filtCnt_q + {{(CW-1){1'b0}}, 1'b1};
        end else begin
          codeValid <= 1'b1;
          filtCode <= rawCode;
        end
      end
    end
  end
endmodule // off_state_channel

// ---- hw/half_bridge_control_diag.v ----
// four half-bridge channels: gate control, protection and off-state diagnosis
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`include "half_bridge_consts.vh"
// Operation
// - enable low forces both switches of the channel off.
// - low-side mode, passive freewheel: low-side follows on, high-side always off.
// - low-side mode, active freewheel: low-side on for on, high-side for off.
// - high-side mode, passive freewheel: high-side follows on, low-side always off.
// - high-side mode, active freewheel: high-side on for on, low-side for off.
// - overcurrent past filter time turns switch off, sets flag, output floats.
// - overtemperature turns outputs off until indication clears.
// - on-state shorts are reported as per-channel overcurrent flags.
// - overtemperature is reported by two pair flags in protect register.
// - off-state detection runs only with both switches off; starts activation timer.
// - after activation time the prioritised result goes into the 2-bit field.
// - a result is stored only after persisting through the filter time.
// - reading the diagnosis register refreshes it to the current state.
// - codes: 00 none, 01 open high-side, 10 open low-side, 11 short.
// - short same in both modes; open load reports open high-side in high-side mode, open low-side in low-side mode.
// - full-bridge enable bits only affect off-state diagnosis of the pair.
// - overcurrent must persist 0.5 to 2 us before switch off.
module half_bridge_control_diag #(
  parameter NCH = 4,
  parameter CW = 24
) (
  input wire clk,
  input wire srst,
  input wire clkEn,
  input wire [3:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWriteData,
  output reg [31:0] avsReadData,
  output reg avsWaitRequest,
  input wire [NCH-1:0] directIn,
  input wire [NCH-1:0] overcurrentIn,
  input wire [NCH-1:0] openLoadIn,
  input wire [NCH-1:0] shortIn,
  input wire [1:0] overtempIn,
  output reg [NCH-1:0] highGate,
  output reg [NCH-1:0] lowGate
);
  localparam integer OC_CYCLES_RAW = (`OC_FILTER_NS * `CLK_MHZ) / 1000;
  localparam [7:0] OC_CYCLES = (OC_CYCLES_RAW < 1) ? 8'h01 : OC_CYCLES_RAW[7:0];
  // timer reset values sized to the counter width
  localparam [CW-1:0] ACT_RESET = `DIAG_ACT_CYCLES;
  localparam [CW-1:0] FILT_RESET = `DIAG_FILT_CYCLES;

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ANSWER = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  // pin synchronisers, two stages each
  reg [NCH-1:0] dirS1_q, dirS2_q, ocS1_q, ocS2_q, olS1_q, olS2_q, scS1_q, scS2_q;
  reg [1:0] otS1_q, otS2_q;
  always @(posedge clk) begin
    if (srst) begin
      dirS1_q <= {NCH{1'b0}};
      dirS2_q <= {NCH{1'b0}};
      ocS1_q <= {NCH{1'b0}};
      ocS2_q <= {NCH{1'b0}};
      olS1_q <= {NCH{1'b0}};
      olS2_q <= {NCH{1'b0}};
      scS1_q <= {NCH{1'b0}};
      scS2_q <= {NCH{1'b0}};
      otS1_q <= 2'h0;
      otS2_q <= 2'h0;
    end else if (clkEn) begin
      dirS1_q <= directIn;
      dirS2_q <= dirS1_q;
      ocS1_q <= overcurrentIn;
      ocS2_q <= ocS1_q;
      olS1_q <= openLoadIn;
      olS2_q <= olS1_q;
      scS1_q <= shortIn;
      scS2_q <= scS1_q;
      otS1_q <= overtempIn;
      otS2_q <= otS1_q;
    end
  end

  // configuration, status and bus state registers
  reg [31:0] bridgeSetup_q;
  reg [NCH-1:0] outputEnable_q;
  reg [2*NCH-1:0] outputControl_q;
  reg [CW-1:0] actTime_q;
  reg [CW-1:0] filtTime_q;
  reg [2*NCH-1:0] offDiag_q;
  reg [NCH-1:0] ocFlag_q;
  reg [1:0] otFlag_q;
  reg [2:0] busState_q;

  wire [NCH-1:0] switchModeSel = bridgeSetup_q[`CFG_MODE_LSB +: NCH];
  wire [NCH-1:0] freewheelSel = bridgeSetup_q[`CFG_FREE_LSB +: NCH];
  wire fullPair1Enable = bridgeSetup_q[`CFG_PAIR1_BIT];
  wire fullPair2Enable = bridgeSetup_q[`CFG_PAIR2_BIT];
  wire [NCH-1:0] channelOnBit = outputControl_q[NCH-1:0];
  wire [NCH-1:0] directSel = outputControl_q[`CTL_DIRECT_SEL_LSB +: NCH];

  // priority encoder shared by all channels
  function [1:0] prioCode;
    input mode;
    input openLoad;
    input short;
    begin
      if (short)
        prioCode = `CODE_SHORT;
      else if (openLoad)
        prioCode = mode ? `CODE_OL_HS : `CODE_OL_LS;
      else
        prioCode = `CODE_NONE;
    end
  endfunction

  wire [NCH-1:0] onReq = (directSel & dirS2_q) | (~directSel & channelOnBit);
  wire [NCH-1:0] latched = ocFlag_q;
  wire otAny = |otS2_q;
  reg [NCH-1:0] hsNext, lsNext;
  integer k;
  always @* begin
    for (k = 0; k < NCH; k = k + 1) begin
      hsNext[k] = 1'b0;
      lsNext[k] = 1'b0;
      if (outputEnable_q[k] && !latched[k] && !otAny) begin
        if (!switchModeSel[k]) begin
          lsNext[k] = onReq[k];
          hsNext[k] = freewheelSel[k] & ~onReq[k];
        end else begin
          hsNext[k] = onReq[k];
          lsNext[k] = freewheelSel[k] & ~onReq[k];
        end
      end
    end
  end

  // overcurrent filter and off-state detection per channel
  wire [NCH-1:0] ocTrip;
  wire [NCH-1:0] codeValid;
  wire [2*NCH-1:0] filtCode;
  wire [NCH-1:0] chOff = ~(highGate | lowGate);
  wire [NCH-1:0] pairOff;
  assign pairOff[0] = fullPair1Enable ? (chOff[0] & chOff[1]) : chOff[0];
  assign pairOff[1] = fullPair1Enable ? (chOff[0] & chOff[1]) : chOff[1];
  assign pairOff[2] = fullPair2Enable ? (chOff[2] & chOff[3]) : chOff[2];
  assign pairOff[3] = fullPair2Enable ? (chOff[2] & chOff[3]) : chOff[3];

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      reg [7:0] ocCnt_q;
      always @(posedge clk) begin
        if (srst)
          ocCnt_q <= 8'h00;
        else if (clkEn) begin
          if (ocS2_q[g] && (highGate[g] || lowGate[g]) && ocCnt_q < OC_CYCLES)
            ocCnt_q <= ocCnt_q + 8'h01;
          else if (!ocS2_q[g])
            ocCnt_q <= 8'h00;
        end
      end
      assign ocTrip[g] = (ocCnt_q >= OC_CYCLES);

      off_state_channel #(.CW(CW)) uDiag (
        .clk(clk),
        .srst(srst),
        .clkEn(clkEn),
        .switchesOff(pairOff[g]),
        .actCycles(actTime_q),
        .filtCycles(filtTime_q),
        .rawCode(prioCode(switchModeSel[g], olS2_q[g], scS2_q[g])),
        .codeValid(codeValid[g]),
        .filtCode(filtCode[2*g +: 2])
      );
    end
  endgenerate

  // live diagnosis view; invalid channels report no failure
  reg [2*NCH-1:0] liveDiag;
  integer j;
  always @* begin
    for (j = 0; j < NCH; j = j + 1)
      liveDiag[2*j +: 2] = codeValid[j] ? filtCode[2*j +: 2] : `CODE_NONE;
  end

  wire rdProtect = (busState_q == ST_ANSWER) && avsRead && (avsAddress == `ADDR_PROTECT);
  wire rdOffDiag = (busState_q == ST_ANSWER) && avsRead && (avsAddress == `ADDR_OFFDIAG);

  always @(posedge clk) begin
    if (srst) begin
      highGate <= {NCH{1'b0}};
      lowGate <= {NCH{1'b0}};
      ocFlag_q <= {NCH{1'b0}};
      otFlag_q <= 2'h0;
      offDiag_q <= {2*NCH{1'b0}};
    end else if (clkEn) begin
      // trip forces the output to float this same edge
      highGate <= hsNext & ~ocTrip;
      lowGate <= lsNext & ~ocTrip;
      // set wins over the clear-on-read
      ocFlag_q <= (rdProtect ? {NCH{1'b0}} : ocFlag_q) | ocTrip;
      otFlag_q <= (rdProtect ? 2'h0 : otFlag_q) | otS2_q;
      if (rdOffDiag)
        offDiag_q <= liveDiag;
      else
        offDiag_q <= offDiag_q | liveDiag;
    end
  end

  // register decode, shared by read mux
  function [31:0] readMux;
    input [3:0] addr;
    begin
      case (addr)
        `ADDR_CFG: readMux = bridgeSetup_q;
        `ADDR_ENABLE: readMux = {{(32-NCH){1'b0}}, outputEnable_q};
        `ADDR_CONTROL: readMux = {{(32-2*NCH){1'b0}}, outputControl_q};
        `ADDR_OFFDIAG: readMux = {{(32-2*NCH){1'b0}}, offDiag_q};
        `ADDR_PROTECT: readMux = {26'h0000000, otFlag_q, ocFlag_q};
        `ADDR_ACT_TIME: readMux = {{(32-CW){1'b0}}, actTime_q};
        `ADDR_FILT_TIME: readMux = {{(32-CW){1'b0}}, filtTime_q};
        default: readMux = 32'h00000000;
      endcase
    end
  endfunction

  // avalon slave: two wait cycles, answer on third cycle of the request
  always @(posedge clk) begin
    if (srst) begin
      busState_q <= ST_IDLE;
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h00000000;
      bridgeSetup_q <= `CFG_RESET;
      outputEnable_q <= {NCH{1'b0}};
      outputControl_q <= {2*NCH{1'b0}};
      actTime_q <= ACT_RESET;
      filtTime_q <= FILT_RESET;
    end else if (clkEn) begin
      case (busState_q)
        ST_IDLE: begin
          avsWaitRequest <= 1'b1;
          if (avsRead || avsWrite)
            busState_q <= ST_ANSWER;
        end
        ST_ANSWER: begin
          avsWaitRequest <= 1'b0;
          avsReadData <= readMux(avsAddress);
          busState_q <= ST_DONE;
          if (avsWrite) begin
            case (avsAddress)
              `ADDR_CFG: bridgeSetup_q <= avsWriteData;
              `ADDR_ENABLE: outputEnable_q <= avsWriteData[NCH-1:0];
              `ADDR_CONTROL: outputControl_q <= avsWriteData[2*NCH-1:0];
              `ADDR_ACT_TIME: actTime_q <= avsWriteData[CW-1:0];
              `ADDR_FILT_TIME: filtTime_q <= avsWriteData[CW-1:0];
              default: begin
              end
            endcase
          end
        end
        ST_DONE: begin
          avsWaitRequest <= 1'b1;
          busState_q <= ST_IDLE;
        end
        default: begin
          avsWaitRequest <= 1'b1;
          busState_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // half_bridge_control_diag

// ---- tb/hb_chk.sv ----
// port-level assertions for the half-bridge control and diagnosis block
module hb_chk #(
  parameter NCH = 4
) (
  input wire clk,
  input wire srst,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsReadData,
  input wire avsWaitRequest,
  input wire [NCH-1:0] overcurrentIn,
  input wire [1:0] overtempIn,
  input wire [NCH-1:0] highGate,
  input wire [NCH-1:0] lowGate
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // reset itself is the antecedent here, so this one must not be disabled by it
  property p_rst; disable iff (1'b0) srst |=> !(highGate | lowGate) && avsWaitRequest; endproperty
  a_rst: assert property (p_rst) else $error("gates or waitrequest wrong after reset");
  property p_noBoth; (highGate & lowGate) == 0; endproperty
  a_noBoth: assert property (p_noBoth) else $error("both switches on");
  property p_waitOne; !avsWaitRequest |=> avsWaitRequest; endproperty
  a_waitOne: assert property (p_waitOne) else $error("waitrequest low too long");
  property p_answer; $rose(avsRead) |-> ##[1:4] !avsWaitRequest; endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_waitCause; $fell(avsWaitRequest) |-> $past(avsRead || avsWrite); endproperty
  a_waitCause: assert property (p_waitCause) else $error("answer without request");
  property p_rdHold; !$fell(avsWaitRequest) |-> $stable(avsReadData); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved outside answer");
  property p_ot; overtempIn != 2'h0 [*4] |-> (highGate | lowGate) == 0; endproperty
  a_ot: assert property (p_ot) else $error("outputs on during overtemperature");
  property p_oc; $rose(|overcurrentIn) |-> ##[1:60] ((highGate | lowGate) & overcurrentIn) == 0;
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent not switched off");
endmodule // hb_chk

// ---- tb/switch_model.sv ----
// behavioural power stages with their off-state and overcurrent comparators
module switch_model #(
  parameter NCH = 4
) (
  input wire [NCH-1:0] highGate,
  input wire [NCH-1:0] lowGate,
  input wire [NCH-1:0] openSel,
  input wire [NCH-1:0] shortSel,
  input wire [NCH-1:0] ocSel,
  output wire [NCH-1:0] openLoadIn,
  output wire [NCH-1:0] shortIn,
  output wire [NCH-1:0] overcurrentIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // a switched-on stage swamps the off-state comparators, so they only speak in off
  assign openLoadIn = openSel & ~(highGate | lowGate);
  assign shortIn = shortSel & ~(highGate | lowGate);
  // no current flows through an open switch, so overcurrent drops once it is off
  assign overcurrentIn = ocSel & (highGate | lowGate);
endmodule // switch_model

// ---- tb/testbench.sv ----
// self-checking bench for the half-bridge control and diagnosis block
`include "half_bridge_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam NCH = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [NCH-1:0] directIn = 4'h0, openSel = 4'h0, shortSel = 4'h0, ocSel = 4'h0;
  logic [1:0] overtempIn = 2'h0;
  wire [31:0] avsReadData;
  wire avsWaitRequest;
  wire [NCH-1:0] overcurrentIn, openLoadIn, shortIn, highGate, lowGate;
  int errors = 0;
  int numChecks = 0;
  logic [31:0] rd;
  always #10 clk = ~clk;
  half_bridge_control_diag #(.NCH(NCH)) dut_u (.clk(clk), .srst(srst), .clkEn(1'b1),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .directIn(directIn), .overcurrentIn(overcurrentIn), .openLoadIn(openLoadIn),
    .shortIn(shortIn), .overtempIn(overtempIn), .highGate(highGate), .lowGate(lowGate));
  switch_model #(.NCH(NCH)) sw_u (.highGate(highGate), .lowGate(lowGate), .openSel(openSel),
    .shortSel(shortSel), .ocSel(ocSel), .openLoadIn(openLoadIn), .shortIn(shortIn),
    .overcurrentIn(overcurrentIn));
  task automatic print_verdict;
    if (errors == 0 && numChecks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 20);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (n >= 20) begin
      errors++;
      print_verdict;
    end
  endtask
  task automatic setup(input logic [3:0] m, f, e, o);
    bus(1'b1, `ADDR_CFG, {24'h0, f, m});
    bus(1'b1, `ADDR_ENABLE, {28'h0, e});
    bus(1'b1, `ADDR_CONTROL, {28'h0, o});
    repeat (4) @(posedge clk);
  endtask
  task automatic t_table;
    logic m, f, e, o, h, l;
    bus(1'b0, 4'hF, 32'h0);
    check("unmapped read", rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      {o, e, f, m} = i[3:0];
      h = e & (m ? o : f & !o);
      l = e & (m ? f & !o : o);
      setup({4{m}}, {4{f}}, {4{e}}, {4{o}});
      check("highGate", {28'h0, highGate}, {28'h0, {4{h}}});
      check("lowGate", {28'h0, lowGate}, {28'h0, {4{l}}});
    end
  endtask
  task automatic t_direct;
    setup(4'h0, 4'h0, 4'hF, 4'h0);
    bus(1'b1, `ADDR_CONTROL, {24'h0, 4'hF, 4'h0});
    directIn <= 4'h6;
    repeat (5) @(posedge clk);
    check("lowGate direct", {28'h0, lowGate}, 32'h6);
    directIn <= 4'h0;
  endtask
  task automatic t_offdiag;
    bus(1'b1, `ADDR_ACT_TIME, 32'h4);
    bus(1'b1, `ADDR_FILT_TIME, 32'h3);
    setup(4'h9, 4'h0, 4'h0, 4'h0);
    openSel <= 4'hD;
    shortSel <= 4'hA;
    repeat (40) @(posedge clk);
    // ch0 open high-side, ch1 short, ch2 open low-side, ch3 open and short
    bus(1'b0, `ADDR_OFFDIAG, 32'h0);
    check("offdiag first", rd, 32'hED);
    bus(1'b0, `ADDR_OFFDIAG, 32'h0);
    check("offdiag second", rd, 32'hED);
    setup(4'h9, 4'h0, 4'hF, 4'hF);
    bus(1'b0, `ADDR_OFFDIAG, 32'h0);
    bus(1'b0, `ADDR_OFFDIAG, 32'h0);
    check("offdiag after on", rd, 32'h0);
  endtask
  task automatic t_protect;
    overtempIn <= 2'h2;
    repeat (5) @(posedge clk);
    check("gates in overtemp", {24'h0, highGate, lowGate}, 32'h0);
    bus(1'b0, `ADDR_PROTECT, 32'h0);
    check("overtemp flags", {30'h0, rd[5:4]}, 32'h2);
    overtempIn <= 2'h0;
    repeat (5) @(posedge clk);
    check("gates after overtemp", {24'h0, highGate, lowGate}, 32'h96);
    bus(1'b0, `ADDR_PROTECT, 32'h0);
    check("overtemp flag held", rd, 32'h20);
    bus(1'b0, `ADDR_PROTECT, 32'h0);
    check("protect cleared", rd, 32'h0);
    ocSel <= 4'h1;
    repeat (20) @(posedge clk);
    check("high in oc filter", {28'h0, highGate}, 32'h9);
    repeat (50) @(posedge clk);
    check("high after oc", {28'h0, highGate}, 32'h8);
    ocSel <= 4'h0;
    repeat (5) @(posedge clk);
    check("high stays off", {28'h0, highGate}, 32'h8);
    bus(1'b0, `ADDR_PROTECT, 32'h0);
    check("oc flags", {28'h0, rd[3:0]}, 32'h1);
    repeat (5) @(posedge clk);
    check("high after restart", {28'h0, highGate}, 32'h9);
  endtask
  // pair 1 as full bridge: ch0 must not diagnose while its partner ch1 is on
  task automatic t_fullpair;
    bus(1'b1, `ADDR_CFG, 32'h100);
    bus(1'b1, `ADDR_ENABLE, 32'hF);
    bus(1'b1, `ADDR_CONTROL, 32'h2);
    repeat (40) @(posedge clk);
    bus(1'b0, `ADDR_OFFDIAG, 32'h0);
    bus(1'b0, `ADDR_OFFDIAG, 32'h0);
    check("offdiag pair half on", rd, 32'hE0);
    bus(1'b1, `ADDR_CONTROL, 32'h0);
    repeat (40) @(posedge clk);
    bus(1'b0, `ADDR_OFFDIAG, 32'h0);
    bus(1'b0, `ADDR_OFFDIAG, 32'h0);
    check("offdiag pair off", rd, 32'hEE);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_table;
    t_direct;
    t_offdiag;
    t_protect;
    t_fullpair;
    print_verdict;
  end
endmodule // testbench
bind half_bridge_control_diag hb_chk #(.NCH(NCH)) chk_u (.clk(clk), .srst(srst),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .overcurrentIn(overcurrentIn), .overtempIn(overtempIn),
  .highGate(highGate), .lowGate(lowGate));
